// [core/pio_ports.sv]
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "pio_defines.svh"

// Summary of operation
// [RULE1] mode 0: port A per-bit direction
// [RULE2] mode 1: port A carries host data
// [RULE3] port B direction only when selected
// [RULE4] unselected port B serves serial pins
// [RULE5] port C low six per-bit direction
// [RULE6] port C top bits read interrupt pins
// [RULE7] writing 1 clears edge capture latch
// [RULE8] one config bit selects port C
// [RULE9] mux bit 3 swaps read/request strobe
// [RULE10] host signals need both enable bits
// [RULE11] direction and data register per port
// [RULE12] all lines input after reset; port B and C lines stay with the serial channels, which may drive them
module pio_ports (
   input wire logic core_clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq,
   // chip mode strap, 0 = port mode, 1 = host mode
   input wire logic chip_mode,
   // port a pads
   input wire logic [7:0] first_port_lines_in,
   output logic [7:0] first_port_lines_out,
   output logic [7:0] first_port_lines_oe_n,
   // port b pads
   input wire logic [7:0] second_port_lines_in,
   output logic [7:0] second_port_lines_out,
   output logic [7:0] second_port_lines_oe_n,
   // port c pads, top two are not pads
   input wire logic [5:0] third_port_low_six_in,
   output logic [5:0] third_port_low_six_out,
   output logic [5:0] third_port_low_six_oe_n,
   // host uart data side
   input wire pio_pkg::alt_drive_t host_data_bus_drive,
   output logic [7:0] host_data_bus_in,
   output logic host_bus_active,
   // serial channels on port b
   input wire pio_pkg::alt_drive_t serial_b_drive,
   output logic [7:0] serial_b_in,
   // serial channel a control on port c
   input wire pio_pkg::alt_drive_t serial_c_drive,
   output logic [5:0] serial_c_in,
   // external interrupt pins
   input wire logic ext_interrupt_one_n,
   input wire logic ext_interrupt_two_n,
   output logic irq_one_req,
   output logic irq_two_req,
   // memory strobes from the cpu core
   input wire logic memory_read_strobe_n,
   input wire logic memory_request_strobe_n,
   output logic mem_strobe_pin_n
);

   pio_pkg::pio_state_t s_reg;  // all registered state
   pio_pkg::pio_state_t s_next;  // next value of the state

   logic [7:0] a_sync;  // port a pad levels
   logic [7:0] b_sync;  // port b pad levels
   logic [5:0] c_sync;  // port c low pad levels
   logic [1:0] int_sync_n;  // interrupt pin levels, active low
   logic mode_sync;  // chip mode level

   logic port_a_sel;  // port a owns pads
   logic port_b_sel;  // port b owns pads
   logic port_c_sel;  // port c owns pads
   logic [1:0] edge_mode;  // 1 = edge capture per interrupt
   logic [1:0] irq_set;  // capture events this cycle
   logic [1:0] irq_clr;  // clears this cycle
   logic wr_now;  // write commits this cycle
   logic rd_now;  // read data latched this cycle
   logic [7:0] wbyte;  // low write byte
   logic [7:0] a_view;  // port a readback
   logic [7:0] b_view;  // port b readback
   logic [7:0] c_view;  // port c readback

   pio_pkg::alt_drive_t host_alt;  // host bus gated by enables
   pio_pkg::pin_drive_t a_pins;
   pio_pkg::pin_drive_t b_pins;
   pio_pkg::pin_drive_t c_pins;
   pio_pkg::alt_drive_t c_alt;  // serial a padded to eight bits

   // pad inputs come from outside the clock domain
   pio_sync2 #(.W(8)) u_sync_a (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in(first_port_lines_in),
      .sync_out(a_sync)
   );

   pio_sync2 #(.W(8)) u_sync_b (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in(second_port_lines_in),
      .sync_out(b_sync)
   );

   // interrupt pins and the mode strap share one synchroniser
   pio_sync2 #(.W(9)) u_sync_c (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in({chip_mode, ext_interrupt_two_n, ext_interrupt_one_n,
                 third_port_low_six_in}),
      .sync_out({mode_sync, int_sync_n, c_sync})
   );

   // ownership decode
   always_comb begin
      // [RULE1] mode 0 port
      port_a_sel = ~mode_sync;
      // [RULE3] config selects port
      port_b_sel = s_reg.sys_cfg[`PIO_SYS_PORT_B_SEL];
      // [RULE8] single select bit
      port_c_sel = s_reg.sys_cfg[`PIO_SYS_PORT_C_SEL];
      // [RULE10] both enables needed
      host_bus_active = mode_sync & s_reg.sys_cfg[`PIO_SYS_HOST_EN]
                        & s_reg.mux_cfg[`PIO_MUX_HOST_EN];
      edge_mode[0] = s_reg.mux_cfg[`PIO_MUX_EXT_INTERRUPT_ONE_N_EDGE];
      edge_mode[1] = s_reg.mux_cfg[`PIO_MUX_EXT_INTERRUPT_TWO_N_EDGE];
   end

   // host bus only reaches the pads once fully enabled
   always_comb begin
      // [RULE2] host bus on a
      host_alt.out = host_data_bus_drive.out;
      host_alt.drive = host_bus_active ? host_data_bus_drive.drive : 8'h00;
   end

   // serial channel a has only six lines here
   always_comb begin
      c_alt.out = {2'b00, serial_c_drive.out[5:0]};
      c_alt.drive = serial_c_drive.drive & `PIO_C_DRIVE_MASK;
   end

   // [RULE1] per-bit port a
   pio_pin_mux u_mux_a (
      .port_sel(port_a_sel),
      .port_dir(s_reg.dir_a),
      .port_data(s_reg.data_a),
      .alt(host_alt),
      .pin(a_pins)
   );

   // [RULE4] serial owns b
   pio_pin_mux u_mux_b (
      .port_sel(port_b_sel),
      .port_dir(s_reg.dir_b),
      .port_data(s_reg.data_b),
      .alt(serial_b_drive),
      .pin(b_pins)
   );

   // [RULE5] low six only
   pio_pin_mux u_mux_c (
      .port_sel(port_c_sel),
      .port_dir(s_reg.dir_c & `PIO_C_DRIVE_MASK),
      .port_data(s_reg.data_c),
      .alt(c_alt),
      .pin(c_pins)
   );

   // pad outputs
   always_comb begin
      first_port_lines_out = a_pins.out;
      first_port_lines_oe_n = a_pins.oe_n;
      second_port_lines_out = b_pins.out;
      second_port_lines_oe_n = b_pins.oe_n;
      third_port_low_six_out = c_pins.out[5:0];
      third_port_low_six_oe_n = c_pins.oe_n[5:0];
   end

   // peripherals always see the pad levels
   always_comb begin
      host_data_bus_in = a_sync;
      serial_b_in = b_sync;
      serial_c_in = c_sync;
   end

   // [RULE9] strobe pin select
   always_comb begin
      if (s_reg.mux_cfg[`PIO_MUX_MEMORY_REQUEST_STROBE_N_SEL]) begin
         mem_strobe_pin_n = memory_request_strobe_n;
      end else begin
         mem_strobe_pin_n = memory_read_strobe_n;
      end
   end

   // readback: output bits show the latch, input bits the pad
   always_comb begin
      a_view = (s_reg.dir_a & s_reg.data_a) | (~s_reg.dir_a & a_sync);
      b_view = (s_reg.dir_b & s_reg.data_b) | (~s_reg.dir_b & b_sync);
      c_view[5:0] = (s_reg.dir_c[5:0] & s_reg.data_c[5:0])
                    | (~s_reg.dir_c[5:0] & c_sync);
      // [RULE6] top bits read pins
      c_view[`PIO_C_IRQ1_BIT] = int_sync_n[0];
      c_view[`PIO_C_IRQ2_BIT] = int_sync_n[1];
   end

   // bus phase: one wait cycle, then the answer
   always_comb begin
      waitrequest = (read | write) & ~s_reg.ack;
      // commit writes on the edge the master sees waitrequest low
      wr_now = write & s_reg.ack & byteenable[0];
      // latch read data in the waited cycle
      rd_now = read & ~s_reg.ack;
      wbyte = writedata[7:0];
   end

   // interrupt capture events
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (edge_mode[i]) begin
            // falling edge of the synced pin
            irq_set[i] = s_reg.int_prev_n[i] & ~int_sync_n[i];
         end else begin
            // level mode: low pin keeps the bit set
            irq_set[i] = ~int_sync_n[i];
         end
      end
   end

   // clear sources: clear register and port c top bits
   always_comb begin
      irq_clr = 2'h0;
      if (wr_now && address == `PIO_OFS_IRQ_CLEAR) begin
         irq_clr = wbyte[1:0];
      end
      // [RULE7] one clears latch
      if (wr_now && address == `PIO_OFS_DATA_C) begin
         irq_clr = irq_clr | (edge_mode &
                   {wbyte[`PIO_C_IRQ2_BIT], wbyte[`PIO_C_IRQ1_BIT]});
      end
   end

   // next state
   always_comb begin
      s_next = s_reg;
      s_next.int_prev_n = int_sync_n;
      // set wins over a clear in the same cycle
      s_next.irq_status = (s_reg.irq_status & ~irq_clr) | irq_set;
      // answer phase toggles once per request
      s_next.ack = (read | write) & ~s_reg.ack;
      // register writes
      if (wr_now) begin
         case (address)
            // [RULE11] per-port registers
            `PIO_OFS_DIR_A: begin
               s_next.dir_a = wbyte;
            end
            `PIO_OFS_DATA_A: begin
               s_next.data_a = wbyte;
            end
            `PIO_OFS_DIR_B: begin
               s_next.dir_b = wbyte;
            end
            `PIO_OFS_DATA_B: begin
               s_next.data_b = wbyte;
            end
            // [RULE5] top direction bits stay input
            `PIO_OFS_DIR_C: begin
               s_next.dir_c = wbyte & `PIO_C_DRIVE_MASK;
            end
            // top data bits are strobes, not storage
            `PIO_OFS_DATA_C: begin
               s_next.data_c = wbyte & `PIO_C_DRIVE_MASK;
            end
            `PIO_OFS_SYS_CFG: begin
               s_next.sys_cfg = wbyte;
            end
            `PIO_OFS_MUX_CFG: begin
               s_next.mux_cfg = wbyte;
            end
            `PIO_OFS_IRQ_ENABLE: begin
               s_next.irq_enable = wbyte[1:0];
            end
            // status is read-only, clear handled above
            default: begin
            end
         endcase
      end
      // read data, unmapped reads give zero
      if (rd_now) begin
         s_next.rdata = 32'h0000_0000;
         case (address)
            `PIO_OFS_DIR_A: begin
               s_next.rdata[7:0] = s_reg.dir_a;
            end
            `PIO_OFS_DATA_A: begin
               s_next.rdata[7:0] = a_view;
            end
            `PIO_OFS_DIR_B: begin
               s_next.rdata[7:0] = s_reg.dir_b;
            end
            `PIO_OFS_DATA_B: begin
               s_next.rdata[7:0] = b_view;
            end
            `PIO_OFS_DIR_C: begin
               s_next.rdata[7:0] = s_reg.dir_c;
            end
            `PIO_OFS_DATA_C: begin
               s_next.rdata[7:0] = c_view;
            end
            `PIO_OFS_SYS_CFG: begin
               s_next.rdata[7:0] = s_reg.sys_cfg;
            end
            `PIO_OFS_MUX_CFG: begin
               s_next.rdata[7:0] = s_reg.mux_cfg;
            end
            `PIO_OFS_IRQ_STATUS: begin
               s_next.rdata[1:0] = s_reg.irq_status;
            end
            `PIO_OFS_IRQ_ENABLE: begin
               s_next.rdata[1:0] = s_reg.irq_enable;
            end
            // clear register reads as zero
            default: begin
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         // [RULE12] inputs after reset
         s_reg.dir_a <= `PIO_RST_DIR;
         s_reg.dir_b <= `PIO_RST_DIR;
         s_reg.dir_c <= `PIO_RST_DIR;
         s_reg.data_a <= `PIO_RST_DATA;
         s_reg.data_b <= `PIO_RST_DATA;
         s_reg.data_c <= `PIO_RST_DATA;
         s_reg.sys_cfg <= `PIO_RST_SYS_CFG;
         s_reg.mux_cfg <= `PIO_RST_MUX_CFG;
         s_reg.irq_status <= `PIO_RST_IRQ;
         s_reg.irq_enable <= `PIO_RST_IRQ;
         s_reg.int_prev_n <= 2'h3;
         s_reg.ack <= 1'b0;
         s_reg.rdata <= 32'h0000_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs to the core
   always_comb begin
      readdata = s_reg.rdata;
      irq = |(s_reg.irq_status & s_reg.irq_enable);
      // edge mode reports the latch, level mode the pin
      irq_one_req = edge_mode[0] ? s_reg.irq_status[0] : ~int_sync_n[0];
      irq_two_req = edge_mode[1] ? s_reg.irq_status[1] : ~int_sync_n[1];
   end

endmodule

// [core/pio_defines.svh]
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// byte offsets on the avalon slave
`define PIO_OFS_DIR_A 6'h00
`define PIO_OFS_DATA_A 6'h04
`define PIO_OFS_DIR_B 6'h08
`define PIO_OFS_DATA_B 6'h0c
`define PIO_OFS_DIR_C 6'h10
`define PIO_OFS_DATA_C 6'h14
`define PIO_OFS_SYS_CFG 6'h18
`define PIO_OFS_MUX_CFG 6'h1c
`define PIO_OFS_IRQ_STATUS 6'h20
`define PIO_OFS_IRQ_ENABLE 6'h24
`define PIO_OFS_IRQ_CLEAR 6'h28

// system config fields
`define PIO_SYS_PORT_B_SEL 0
`define PIO_SYS_HOST_EN 1
`define PIO_SYS_PORT_C_SEL 2

// edge / pin mux config fields
`define PIO_MUX_EXT_INTERRUPT_ONE_N_EDGE 0
`define PIO_MUX_EXT_INTERRUPT_TWO_N_EDGE 1
`define PIO_MUX_MEMORY_REQUEST_STROBE_N_SEL 3
`define PIO_MUX_HOST_EN 4

// port c upper bits tied to the interrupt pins
`define PIO_C_IRQ1_BIT 6
`define PIO_C_IRQ2_BIT 7

// reset values
`define PIO_RST_DIR 8'h00
`define PIO_RST_DATA 8'h00
`define PIO_RST_SYS_CFG 8'h00
`define PIO_RST_MUX_CFG 8'h00
`define PIO_RST_IRQ 2'h0

// port c lines that may be driven at all
`define PIO_C_DRIVE_MASK 8'h3f

`endif

// [core/pio_pkg.sv]
package pio_pkg;

   // one tri-state pin group as seen by the pad ring
   typedef struct packed {
      logic [7:0] out;  // level driven when enabled
      logic [7:0] oe_n;  // low = pad driven
   } pin_drive_t;

   // alternate function drive request for a pin group
   typedef struct packed {
      logic [7:0] out;  // level from the peripheral
      logic [7:0] drive;  // high = peripheral wants the pad
   } alt_drive_t;

   // whole register state of the port block
   typedef struct packed {
      logic [7:0] dir_a;  // 1 = output
      logic [7:0] data_a;
      logic [7:0] dir_b;
      logic [7:0] data_b;
      logic [7:0] dir_c;
      logic [7:0] data_c;
      logic [7:0] sys_cfg;
      logic [7:0] mux_cfg;
      logic [1:0] irq_status;  // bit0 irq one, bit1 irq two
      logic [1:0] irq_enable;
      logic [1:0] int_prev_n;  // last synced interrupt pin levels
      logic ack;  // bus answer phase
      logic [31:0] rdata;
   } pio_state_t;

endpackage

// [core/pio_sync2.sv]
`timescale 1ns/1ns
// two flop synchroniser for pin levels
module pio_sync2 #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;  // first stage, read only by second stage
   logic [W-1:0] sync_reg;  // stable copy

   // reset to idle-high so active-low pins look quiet
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '1;
         sync_reg <= '1;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule

// [core/pio_pin_mux.sv]
`timescale 1ns/1ns
// whole-group choice between port latch and alternate function
module pio_pin_mux (
   input wire logic port_sel,
   input wire logic [7:0] port_dir,
   input wire logic [7:0] port_data,
   input wire pio_pkg::alt_drive_t alt,
   output pio_pkg::pin_drive_t pin
);

   genvar i;
   // one identical slice per line
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         always_comb begin
            if (port_sel) begin
               // port owns the pad
               pin.out[i] = port_data[i];
               pin.oe_n[i] = ~port_dir[i];
            end else begin
               // peripheral owns the pad
               pin.out[i] = alt.out[i];
               pin.oe_n[i] = ~alt.drive[i];
            end
         end
      end
   endgenerate

endmodule

// [dv/pio_ports_chk.sv]
`timescale 1ns/1ns
// watches the port block from its pins only
module pio_ports_chk (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic irq,
   input wire logic [7:0] first_port_lines_oe_n,
   input wire logic [7:0] second_port_lines_oe_n,
   input wire pio_pkg::alt_drive_t serial_b_drive,
   input wire logic ext_interrupt_one_n,
   input wire logic ext_interrupt_two_n,
   input wire logic irq_one_req,
   input wire logic irq_two_req,
   input wire logic memory_read_strobe_n,
   input wire logic memory_request_strobe_n,
   input wire logic mem_strobe_pin_n
);
   // one clock domain, so one default for all
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   chk_wait_one: assert property ((read | write) && waitrequest |=> !waitrequest)
      else $error("bus answer later than one wait cycle");
   chk_wait_first: assert property ($rose(read | write) |-> waitrequest)
      else $error("bus answered without a wait cycle");
   chk_wait_idle: assert property (!(read | write) |-> !waitrequest)
      else $error("wait raised with no request");
   chk_rd_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_reset_input: assert property ($rose(nrst) |-> first_port_lines_oe_n == 8'hff
      && second_port_lines_oe_n == ~serial_b_drive.drive)
      else $error("pad driven right after reset");
   chk_irq_sticky: assert property ($fell(irq) |-> $past(write))
      else $error("interrupt dropped without a write");
   chk_ext_interrupt_one_n_seen: assert property ($fell(ext_interrupt_one_n) ##1
      !ext_interrupt_one_n [*3] |-> ##[0:2] irq_one_req)
      else $error("interrupt one pin fall not seen");
   chk_ext_interrupt_two_n_seen: assert property ($fell(ext_interrupt_two_n) ##1
      !ext_interrupt_two_n [*3] |-> ##[0:2] irq_two_req)
      else $error("interrupt two pin fall not seen");
   chk_strobe_src: assert property (mem_strobe_pin_n == memory_read_strobe_n
      || mem_strobe_pin_n == memory_request_strobe_n)
      else $error("strobe pin from neither source");
endmodule

bind pio_ports pio_ports_chk chk (.core_clk, .nrst, .read, .write, .readdata, .waitrequest,
   .irq, .first_port_lines_oe_n, .second_port_lines_oe_n, .serial_b_drive,
   .ext_interrupt_one_n, .ext_interrupt_two_n, .irq_one_req, .irq_two_req,
   .memory_read_strobe_n, .memory_request_strobe_n, .mem_strobe_pin_n);

// [dv/pio_board.sv]
`timescale 1ns/1ns
// board side of the three pin groups
module pio_board (
   input wire pio_pkg::pin_drive_t pin_a,
   input wire pio_pkg::pin_drive_t pin_b,
   input wire pio_pkg::pin_drive_t pin_c,
   input wire logic [7:0] board,
   output logic [7:0] pad_a,
   output logic [7:0] pad_b,
   output logic [7:0] pad_c
);
   // released lines take the board level, never the chip's last value
   assign pad_a = (pin_a.out & ~pin_a.oe_n) | (board & pin_a.oe_n);
   assign pad_b = (pin_b.out & ~pin_b.oe_n) | (board & pin_b.oe_n);
   // port c gets the inverse so a swapped group shows up
   assign pad_c = (pin_c.out & ~pin_c.oe_n) | (~board & pin_c.oe_n);
endmodule

// [dv/parallel_ports_pin_sharing_tb_top.sv]
`timescale 1ns/1ns
`include "pio_defines.svh"
// drives the port block through its register bus and its pins
module parallel_ports_pin_sharing_tb_top;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'h1;
   logic [31:0] writedata = 32'h0;
   logic chip_mode = 1'b0;
   logic ext_interrupt_one_n_n = 1'b1;
   logic ext_interrupt_two_n_n = 1'b1;
   logic mrd_n = 1'b0;
   logic memory_request_strobe_n_n = 1'b1;
   logic [7:0] board = 8'h5a; // level on lines nobody else drives
   pio_pkg::alt_drive_t host_drv = '0;
   pio_pkg::alt_drive_t ser_b = '0;
   pio_pkg::alt_drive_t ser_c = '0;
   pio_pkg::pin_drive_t pin_a, pin_b;
   logic [5:0] c_out, c_oe_n, ser_c_in;
   logic [7:0] pad_a, pad_b, pad_c, host_in, ser_b_in;
   logic [31:0] readdata, rd;
   logic waitrequest, irq, host_act, req1, req2, strobe_n;
   int err_count = 0;
   int checked = 0;

   // 10 MHz
   always #50 core_clk = ~core_clk;

   pio_ports DUT (.core_clk, .nrst, .address, .read, .write, .byteenable, .writedata,
      .readdata, .waitrequest, .irq, .chip_mode, .first_port_lines_in(pad_a),
      .first_port_lines_out(pin_a.out), .first_port_lines_oe_n(pin_a.oe_n),
      .second_port_lines_in(pad_b), .second_port_lines_out(pin_b.out),
      .second_port_lines_oe_n(pin_b.oe_n), .third_port_low_six_in(pad_c[5:0]),
      .third_port_low_six_out(c_out), .third_port_low_six_oe_n(c_oe_n),
      .host_data_bus_drive(host_drv), .host_data_bus_in(host_in), .host_bus_active(host_act),
      .serial_b_drive(ser_b), .serial_b_in(ser_b_in), .serial_c_drive(ser_c),
      .serial_c_in(ser_c_in),
      .ext_interrupt_one_n(ext_interrupt_one_n_n), .ext_interrupt_two_n(ext_interrupt_two_n_n), .irq_one_req(req1),
      .irq_two_req(req2), .memory_read_strobe_n(mrd_n), .memory_request_strobe_n(memory_request_strobe_n_n),
      .mem_strobe_pin_n(strobe_n));

   // board model on the pads
   pio_board board_side (.pin_a, .pin_b, .pin_c({2'b00, c_out, 2'b11, c_oe_n}), .board,
      .pad_a, .pad_b, .pad_c);

   // verdict and end of run
   task automatic wrap_up();
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   // one avalon cycle, held until wait is seen low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge core_clk);
      address <= a;
      read <= !wr;
      write <= wr;
      byteenable <= be;
      writedata <= {24'h0, d};
      // wait and read data are looked at right on each rising edge,
      // before the design's updates for that edge land
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("CHECK FAILED %0t bus timeout", $time);
         wrap_up();
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // one more edge so a committed write is settled before any check
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask

   task automatic rc(input logic [5:0] a, input logic [7:0] e, input string m);
      bus(1'b0, a, 8'h00, 4'h1);
      chk(rd, {24'h0, e}, m);
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      // reset state: all lines input
      for (int i = 0; i < 3; i++) begin
         rc(6'(i * 8), 8'h00, "direction not reset");
      end
      chk(pin_a.oe_n, 8'hff, "port a driven after reset");
      chk(c_oe_n, 6'h3f, "port c driven after reset");
      // port a per-bit direction in port mode
      wr(`PIO_OFS_DIR_A, 8'ha5);
      wr(`PIO_OFS_DATA_A, 8'h3c);
      chk(pin_a.oe_n, 8'h5a, "port a enables");
      chk(pin_a.out & 8'ha5, 8'h24, "port a levels");
      rc(`PIO_OFS_DATA_A, (8'h3c & 8'ha5) | (board & 8'h5a), "port a readback");
      // port b owned by serial until selected
      ser_b <= '{out: 8'h3c, drive: 8'hf0};
      wr(`PIO_OFS_DIR_B, 8'hff);
      chk(pin_b.oe_n, 8'h0f, "serial lost port b");
      chk(ser_b_in, 8'h3a, "serial input from port b");
      wr(`PIO_OFS_SYS_CFG, 8'h01);
      chk(pin_b.oe_n, 8'h00, "port b direction ignored");
      // port c low six, own select bit; driven bits differ from the board's inverse
      ser_c <= '{out: 8'h2a, drive: 8'h0c};
      wr(`PIO_OFS_DIR_C, 8'hff);
      chk(c_oe_n, 6'h33, "serial lost port c");
      chk(ser_c_in, 6'h29, "serial input from port c");
      rc(`PIO_OFS_DIR_C, 8'h3f, "port c top bits stored");
      wr(`PIO_OFS_SYS_CFG, 8'h05);
      chk(c_oe_n, 6'h00, "port c direction ignored");
      // top bits read the interrupt pins
      ext_interrupt_two_n_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      rc(`PIO_OFS_DATA_C, 8'h40, "port c top bits");
      // edge capture, mask and clear
      ext_interrupt_two_n_n <= 1'b1;
      wr(`PIO_OFS_MUX_CFG, 8'h03);
      wr(`PIO_OFS_IRQ_CLEAR, 8'h03);
      rc(`PIO_OFS_IRQ_STATUS, 8'h00, "status not cleared");
      wr(`PIO_OFS_IRQ_ENABLE, 8'h03);
      ext_interrupt_one_n_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      chk(irq, 1'b1, "no interrupt on edge");
      wr(`PIO_OFS_DATA_C, 8'h00);
      rc(`PIO_OFS_IRQ_STATUS, 8'h01, "zero write cleared latch");
      wr(`PIO_OFS_IRQ_ENABLE, 8'h00);
      chk(irq, 1'b0, "masked interrupt seen");
      wr(`PIO_OFS_IRQ_ENABLE, 8'h03);
      wr(`PIO_OFS_DATA_C, 8'h40);
      rc(`PIO_OFS_IRQ_STATUS, 8'h00, "one write left latch");
      chk(irq, 1'b0, "interrupt after clear");
      ext_interrupt_two_n_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      wr(`PIO_OFS_IRQ_STATUS, 8'h00);
      rc(`PIO_OFS_IRQ_STATUS, 8'h02, "status took a write");
      wr(`PIO_OFS_IRQ_CLEAR, 8'h02);
      rc(`PIO_OFS_IRQ_STATUS, 8'h00, "clear register failed");
      // refused accesses
      rc(6'h2c, 8'h00, "unmapped read");
      rc(`PIO_OFS_IRQ_CLEAR, 8'h00, "clear reads back");
      bus(1'b1, `PIO_OFS_DIR_B, 8'h00, 4'h0);
      rc(`PIO_OFS_DIR_B, 8'hff, "byte lane off still wrote");
      // host mode needs both enables
      host_drv <= '{out: 8'h96, drive: 8'hff};
      chip_mode <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk(pin_a.oe_n, 8'hff, "port a still driven in host mode");
      wr(`PIO_OFS_SYS_CFG, 8'h07);
      chk(host_act, 1'b0, "host active on one enable");
      wr(`PIO_OFS_MUX_CFG, 8'h13);
      chk(host_act, 1'b1, "host not active");
      chk(pin_a, {8'h96, 8'h00}, "host data not on port a");
      // the new pad level needs two edges through the synchroniser
      repeat (2) @(posedge core_clk);
      chk(host_in, 8'h96, "host data input");
      // strobe pin source
      chk(strobe_n, 1'b0, "read strobe not on pin");
      wr(`PIO_OFS_MUX_CFG, 8'h1b);
      chk(strobe_n, 1'b1, "request strobe not on pin");
      // second reset in mid-run
      nrst <= 1'b0;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      rc(`PIO_OFS_DIR_B, 8'h00, "dir b after second reset");
      chk(pin_a.oe_n, 8'hff, "port a driven after second reset");
      wrap_up();
   end
endmodule
